// ==== hw/key_wakeup_pkg.sv ====
// Package with the register map, field layout and timing constants of the key wakeup block.
package key_wakeup_pkg;

    // Register addresses on the plain register port.
    localparam logic [11:0] WAKE_EN_OFFSET    = 12'hf9a;
    localparam logic [11:0] HALT_CTRL_OFFSET  = 12'hf9b;
    localparam logic [11:0] HALT_STAT_OFFSET  = 12'hf9c;

    // Field positions.
    localparam int          WAKE_EN_LSB       = 4;
    localparam int          AUX_PIN_COUNT     = 4;
    localparam int          CTRL_RELM_BIT     = 0;
    localparam int          CTRL_HALT_BIT     = 1;
    localparam int          STAT_HALT_BIT     = 0;
    localparam int          STAT_WARM_BIT     = 1;
    localparam int          STAT_MAIN_BIT     = 2;
    localparam int          STAT_PORT_LSB     = 4;

    // Values after reset.
    localparam logic [3:0]  WAKE_EN_RESET     = 4'h0;
    localparam logic        RELM_RESET        = 1'b0;

    // Warm-up time after a release, in ns, and its length in clock cycles.
    localparam int          CLK_PERIOD_NS     = 5;
    localparam int          WARMUP_TIME_NS    = 80;
    localparam int          WARMUP_CYCLES     = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;

    // Power state of the device.
    typedef enum logic [2:0]
    {
        ST_RUN    = 3'b001,
        ST_HALT   = 3'b010,
        ST_WARMUP = 3'b100
    } power_state_t;

endpackage

// ==== hw/key_wakeup_release.sv ====
// Key-on wakeup logic that releases the low-power halt state.
//
// Overview of operation
// - Main wake pin and four auxiliary wake pins release the halt, the auxiliary pins in level mode only.
// - Each auxiliary pin has its own enable bit: 0 disables, 1 enables.
// - Enable bits sit at bits 7:4, write-only, reset to zero; low bits undefined.
// - In level mode, a low level on any enabled auxiliary pin releases halt.
// - A release condition at halt request skips halt and starts warm-up at once.
// - Main wake pin has no enable and always acts as a release source.
// - Wake detector has its own input stage, separate from the port input.
`timescale 1ns/1ps
module key_wakeup_release
    import key_wakeup_pkg::*;
#(
    parameter int WARMUP_LEN = key_wakeup_pkg::WARMUP_CYCLES
)
(
    clk_sys,
    rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    ext_irq_five,
    aux_wake_pin_a,
    aux_wake_pin_b,
    aux_wake_pin_c,
    aux_wake_pin_d,
    halt_active,
    warmup_active,
    wake_release,
    main_wake_irq
);
    input  wire logic       clk_sys;
    input  wire logic       rst;
    input  wire logic [11:0] reg_addr;
    input  wire logic [7:0] reg_wdata;
    input  wire logic       reg_wr;
    input  wire logic       reg_rd;
    output logic      [7:0] reg_rdata;
    input  wire logic       ext_irq_five;
    input  wire logic       aux_wake_pin_a;
    input  wire logic       aux_wake_pin_b;
    input  wire logic       aux_wake_pin_c;
    input  wire logic       aux_wake_pin_d;
    output logic            halt_active;
    output logic            warmup_active;
    output logic            wake_release;
    output logic            main_wake_irq;

    import key_wakeup_pkg::*;

    localparam int CNT_W = $clog2(WARMUP_LEN + 1);

    initial
    begin
        if (WARMUP_LEN < 1)
        begin
            $error("key_wakeup_release needs a warm-up of at least one cycle.");
        end
    end

    // Pin groups: main pin in bit 4, auxiliary pins a..d in bits 0..3.
    logic [4:0]       pins_raw;
    logic [4:0]       wake_seen;
    logic [4:0]       port_seen;

    assign pins_raw = {ext_irq_five, aux_wake_pin_d, aux_wake_pin_c,
                       aux_wake_pin_b, aux_wake_pin_a};

    // The wake detector and the port read path have separate input stages, so a
    // port read taken before halt may not match what the detector sees.
    // The main pin idles low and the auxiliary pins idle high.
    wake_input_stage #(.WIDTH(5), .IDLE(5'h0f)) u_wake_stage
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   (pins_raw),
        .pin_sync (wake_seen)
    );

    wake_input_stage #(.WIDTH(5), .IDLE(5'h0f)) u_port_stage
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   (pins_raw),
        .pin_sync (port_seen)
    );

    // Register state.
    logic [3:0]       wake_en_ff;
    logic [3:0]       nxt_wake_en;
    logic             relm_ff;
    logic             nxt_relm;
    logic [7:0]       rdata_ff;
    logic [7:0]       nxt_rdata;
    logic             halt_req;

    // Power state.
    power_state_t     state_ff;
    power_state_t     nxt_state;
    logic [CNT_W-1:0] warm_cnt_ff;
    logic [CNT_W-1:0] nxt_warm_cnt;
    logic             main_prev_ff;
    logic             nxt_main_prev;
    logic             release_ff;
    logic             nxt_release;

    // Release terms.
    logic             main_high;
    logic             main_rise;
    logic [3:0]       aux_low;
    logic             aux_req;
    logic             level_release;
    logic             halt_release;

    // Register writes. The enable register is write-only and its low nibble is
    // dropped, so nothing software puts there can disturb the release logic.
    always_comb
    begin
        nxt_wake_en = wake_en_ff;
        nxt_relm    = relm_ff;
        halt_req    = 1'b0;
        if (reg_wr && reg_addr == WAKE_EN_OFFSET)
        begin
            nxt_wake_en = reg_wdata[WAKE_EN_LSB +: AUX_PIN_COUNT];
        end
        if (reg_wr && reg_addr == HALT_CTRL_OFFSET)
        begin
            nxt_relm = reg_wdata[CTRL_RELM_BIT];
            halt_req = reg_wdata[CTRL_HALT_BIT];
        end
    end

    // Read data stand only in the cycle after the read strobe.
    // The write-only enable register and unmapped addresses read as zero.
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (reg_rd && reg_addr == HALT_CTRL_OFFSET)
        begin
            nxt_rdata[CTRL_RELM_BIT] = relm_ff;
        end
        else if (reg_rd && reg_addr == HALT_STAT_OFFSET)
        begin
            nxt_rdata[STAT_HALT_BIT] = state_ff == ST_HALT;
            nxt_rdata[STAT_WARM_BIT] = state_ff == ST_WARMUP;
            nxt_rdata[STAT_MAIN_BIT] = port_seen[4];
            nxt_rdata[STAT_PORT_LSB +: AUX_PIN_COUNT] = port_seen[3:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wake_en_ff <= WAKE_EN_RESET;
            relm_ff    <= RELM_RESET;
            rdata_ff   <= 8'h00;
        end
        else
        begin
            wake_en_ff <= nxt_wake_en;
            relm_ff    <= nxt_relm;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Release detection. The main pin has no enable and always counts; the
    // auxiliary pins count here only in level mode, though a halt request checks them in either mode.
    always_comb
    begin
        main_high     = wake_seen[4];
        main_rise     = wake_seen[4] && !main_prev_ff;
        aux_low       = wake_en_ff & ~wake_seen[3:0];
        aux_req       = relm_ff && (|aux_low);
        level_release = main_high || aux_req;
        halt_release  = relm_ff ? level_release : main_rise;
    end

    // Power state machine: a halt request with a release already present goes
    // straight to warm-up, otherwise the device halts until a release arrives.
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_warm_cnt  = warm_cnt_ff;
        nxt_main_prev = wake_seen[4];
        nxt_release   = 1'b0;
        unique case (state_ff)
            ST_RUN:
            begin
                if (halt_req)
                begin
                    if (main_high || (|aux_low))
                    begin
                        nxt_state    = ST_WARMUP;
                        nxt_warm_cnt = CNT_W'(WARMUP_LEN);
                        nxt_release  = 1'b1;
                    end
                    else
                    begin
                        nxt_state = ST_HALT;
                    end
                end
            end
            ST_HALT:
            begin
                if (halt_release)
                begin
                    nxt_state    = ST_WARMUP;
                    nxt_warm_cnt = CNT_W'(WARMUP_LEN);
                    nxt_release  = 1'b1;
                end
            end
            ST_WARMUP:
            begin
                if (warm_cnt_ff <= CNT_W'(1))
                begin
                    nxt_state    = ST_RUN;
                    nxt_warm_cnt = '0;
                end
                else
                begin
                    nxt_warm_cnt = warm_cnt_ff - CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff     <= ST_RUN;
            warm_cnt_ff  <= '0;
            main_prev_ff <= 1'b0;
            release_ff   <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            warm_cnt_ff  <= nxt_warm_cnt;
            main_prev_ff <= nxt_main_prev;
            release_ff   <= nxt_release;
        end
    end

    // Outputs come from flops or from compares of state_ff; the main pin doubles as an interrupt level.
    assign reg_rdata     = rdata_ff;
    assign halt_active   = state_ff == ST_HALT;
    assign warmup_active = state_ff == ST_WARMUP;
    assign wake_release  = release_ff;
    assign main_wake_irq = wake_seen[4];

endmodule

// ==== hw/wake_input_stage.sv ====
// Two-flop input stage for a group of asynchronous pins.
`timescale 1ns/1ps
module wake_input_stage
#(
    parameter int               WIDTH = 5,
    parameter logic [WIDTH-1:0] IDLE  = '1
)
(
    clk_sys,
    rst,
    pin_in,
    pin_sync
);
    input  wire logic             clk_sys;
    input  wire logic             rst;
    input  wire logic [WIDTH-1:0] pin_in;
    output logic      [WIDTH-1:0] pin_sync;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("wake_input_stage needs at least one pin.");
        end
    end

    // One synchroniser per pin; the first flop feeds only the second.
    // Each flop resets to its pin's idle level, so no false level or edge follows reset.
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_sync
        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
            begin
                meta_ff[i] <= IDLE[i];
                sync_ff[i] <= IDLE[i];
            end
            else
            begin
                meta_ff[i] <= pin_in[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    assign pin_sync = sync_ff;

endmodule

// ==== testbench/key_pad_model.sv ====
// Model of the external key switches that drive the wake pins.
`timescale 1ns/1ps
module key_pad_model
(
    input  wire logic [3:0] key_down,
    input  wire logic       main_key,
    output logic            pin_a,
    output logic            pin_b,
    output logic            pin_c,
    output logic            pin_d,
    output logic            pin_main
);
    // A released key leaves its pin on the pull-up, so the idle level is high.
    assign {pin_d, pin_c, pin_b, pin_a} = ~key_down;
    // The main pin stays low unless pressed, so it cannot mask an aux release.
    assign pin_main = main_key;
endmodule

// ==== testbench/key_wakeup_monitor.sv ====
// Assertions on the ports of the key wakeup block.
`timescale 1ns/1ps
module key_wakeup_monitor
    import key_wakeup_pkg::*;
#(
    parameter int WARMUP_LEN = WARMUP_CYCLES
)
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        halt_active,
    input wire logic        warmup_active,
    input wire logic        wake_release,
    input wire logic        main_wake_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A halt request that arrives while the block is running.
    logic       halt_req;
    logic [7:0] warm_cnt_ff;
    logic [7:0] nxt_warm_cnt;
    assign halt_req = reg_wr && reg_addr == HALT_CTRL_OFFSET && reg_wdata[CTRL_HALT_BIT]
                      && !halt_active && !warmup_active;

    // Counting warm-up cycles avoids a long repetition in the length check.
    always_comb nxt_warm_cnt = warmup_active ? warm_cnt_ff + 8'h01 : 8'h00;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            warm_cnt_ff <= 8'h00;
        else
            warm_cnt_ff <= nxt_warm_cnt;

    property p_wo;
        reg_rd && reg_addr == WAKE_EN_OFFSET |=> reg_rdata == 8'h00;
    endproperty
    a_wo: assert property (p_wo) else $error("enable register read back");
    property p_entry;
        halt_req |=> halt_active != warmup_active;
    endproperty
    a_entry: assert property (p_entry) else $error("halt request lost");
    property p_refuse;
        halt_req && main_wake_irq |=> warmup_active && wake_release;
    endproperty
    a_refuse: assert property (p_refuse) else $error("halt not refused");
    property p_main;
        halt_active && main_wake_irq |-> ##[1:2] !halt_active;
    endproperty
    a_main: assert property (p_main) else $error("main pin ignored");
    property p_pulse;
        wake_release |=> !wake_release;
    endproperty
    a_pulse: assert property (p_pulse) else $error("release pulse too long");
    property p_rel;
        wake_release |-> warmup_active && !$past(warmup_active);
    endproperty
    a_rel: assert property (p_rel) else $error("release not at warm-up start");
    property p_len;
        $fell(warmup_active) |-> warm_cnt_ff == 8'(WARMUP_LEN);
    endproperty
    a_len: assert property (p_len) else $error("warm-up length wrong");
    property p_excl;
        !(halt_active && warmup_active);
    endproperty
    a_excl: assert property (p_excl) else $error("halt and warm-up together");

    c_release: cover property (halt_active ##1 wake_release);
    c_refused: cover property (halt_req ##1 wake_release);
    c_done:    cover property ($fell(warmup_active));
endmodule

bind key_wakeup_release key_wakeup_monitor #(.WARMUP_LEN(WARMUP_LEN)) u_mon
(
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_active(halt_active), .warmup_active(warmup_active),
    .wake_release(wake_release), .main_wake_irq(main_wake_irq)
);

// ==== testbench/tb.sv ====
// Testbench for the key wakeup block through registers and key pins.
`timescale 1ns/1ps
module tb;
    import key_wakeup_pkg::*;
    localparam int WL = 2;
    logic        clk_sys, rst, reg_wr, reg_rd, main_key;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [3:0]  key_down;
    logic        pa, pb, pc, pd, pm, halt_active, warmup_active, wake_release, main_wake_irq;
    int          errors, num_checks, n;

    key_pad_model keys (.key_down(key_down), .main_key(main_key), .pin_a(pa), .pin_b(pb),
                        .pin_c(pc), .pin_d(pd), .pin_main(pm));
    key_wakeup_release #(.WARMUP_LEN(WL)) dut
    (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_five(pm),
        .aux_wake_pin_a(pa), .aux_wake_pin_b(pb), .aux_wake_pin_c(pc), .aux_wake_pin_d(pd),
        .halt_active(halt_active), .warmup_active(warmup_active),
        .wake_release(wake_release), .main_wake_irq(main_wake_irq)
    );

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Outputs are looked at 1 ns after the edge, once its updates have landed.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Waits a bounded time for the release pulse, then measures the warm-up.
    task automatic wake_warm;
        n = 0;
        while (wake_release !== 1'b1 && n < 10)
        begin
            cyc(1);
            n++;
        end
        chk(wake_release, 1);
        if (wake_release !== 1'b1)
            final_report;
        n = 0;
        while (warmup_active === 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        chk(8'(n), 8'(WL));
        if (n >= 20)
            final_report;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, main_key, key_down, reg_addr, reg_wdata} = '0;
        {errors, num_checks, n} = '0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        cyc(3);
        chk({halt_active, warmup_active, wake_release, main_wake_irq}, 0);
        rd(WAKE_EN_OFFSET, 8'h00);
        rd(12'h123, 8'h00);
        rd(HALT_STAT_OFFSET, 8'hf0);
        for (int i = 0; i < 4; i++)
        begin
            wr(WAKE_EN_OFFSET, (8'h10 << i) | 8'h0f);
            wr(HALT_CTRL_OFFSET, 8'h03);
            chk(halt_active, 1);
            rd(HALT_STAT_OFFSET, 8'hf1);
            rd(HALT_CTRL_OFFSET, 8'h01);
            key_down <= 4'h1 << ((i + 1) % 4);
            cyc(6);
            chk(halt_active, 1);
            key_down <= 4'h1 << i;
            wake_warm();
            key_down <= 4'h0;
            cyc(3);
        end
        // An enabled key already down must turn the halt into a warm-up.
        wr(WAKE_EN_OFFSET, 8'h80);
        key_down <= 4'h8;
        cyc(4);
        wr(HALT_CTRL_OFFSET, 8'h03);
        chk(wake_release, 1);
        wake_warm();
        key_down <= 4'h0;
        wr(WAKE_EN_OFFSET, 8'h00);
        main_key <= 1'b1;
        cyc(4);
        chk(main_wake_irq, 1);
        wr(HALT_CTRL_OFFSET, 8'h02);
        chk(warmup_active, 1);
        wake_warm();
        main_key <= 1'b0;
        cyc(4);
        chk(main_wake_irq, 0);
        wr(HALT_CTRL_OFFSET, 8'h02);
        key_down <= 4'hf;
        cyc(6);
        chk(halt_active, 1);
        main_key <= 1'b1;
        wake_warm();
        // Level mode with no auxiliary pin enabled: the main pin alone releases.
        main_key <= 1'b0;
        key_down <= 4'h0;
        cyc(4);
        wr(HALT_CTRL_OFFSET, 8'h03);
        chk(halt_active, 1);
        wr(HALT_CTRL_OFFSET, 8'h03);
        chk(halt_active, 1);
        main_key <= 1'b1;
        wake_warm();
        cyc(4);
        final_report;
    end
endmodule
